// *** fpa_map.vh ***
// constants for the flow output pin and alarm block
`ifndef FPA_MAP_VH
`define FPA_MAP_VH
// pin assignment codes
`define FPA_PIN_UNUSED 2'h0
`define FPA_PIN_INPUT 2'h1
`define FPA_PIN_OUTPUT 2'h2
// output function codes
`define FPA_FN_PULSE 2'h0
`define FPA_FN_SINGLE 2'h1
`define FPA_FN_DUAL 2'h2
`define FPA_FN_REVERSE 2'h3
// latching codes
`define FPA_LATCH_NONE 2'h0
`define FPA_LATCH_HIGH 2'h1
`define FPA_LATCH_LOW 2'h2
// timing
`define FPA_CLK_MHZ 125
`define FPA_HOLD_S 4
`define FPA_HOLD_CYCLES (`FPA_HOLD_S * `FPA_CLK_MHZ * 1000000)
`define FPA_PULSE_MAX_HZ 1000
`define FPA_PULSE_MIN_CYCLES (`FPA_CLK_MHZ * 1000000 / `FPA_PULSE_MAX_HZ / 2)
// damping levels 0..5
`define FPA_DAMP_MAX 3'h5
// register offsets
`define FPA_A_CFG 4'h0
`define FPA_A_PINA 4'h1
`define FPA_A_PINB 4'h2
`define FPA_A_THA 4'h3
`define FPA_A_THB 4'h4
`define FPA_A_CUT 4'h5
`define FPA_A_PPV 4'h6
`define FPA_A_TOT 4'h7
`define FPA_A_STAT 4'h8
`define FPA_A_UNIT 4'h9
// reset values of the pulse scaling
`define FPA_PPV_RST 16'h0001
`define FPA_UNIT_RST 32'h000003E8
`endif

// *** fpa_sync.v ***
// two flip-flop synchroniser for one pin level
`default_nettype none
module fpa_sync (
	// clock and reset
	input wire sys_clk_in,
	input wire sys_rst_in,
	// level in and out
	input wire d_in,
	output reg q_out
);
	reg meta; // first stage, read only by q_out

	// plain two-stage crossing
	always @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			meta <= 1'b0;
			q_out <= 1'b0;
		end else begin
			meta <= d_in;
			q_out <= meta;
		end
	end
endmodule
`default_nettype wire

// *** fpa_alarm.v ***
// one output pin: pulse, alarm or reverse-flow function
`default_nettype none
`include "fpa_map.vh"
module fpa_alarm #(
	parameter W = 24,
	parameter [31:0] PULSE_MIN = `FPA_PULSE_MIN_CYCLES
) (
	// clock and reset
	input wire sys_clk_in,
	input wire sys_rst_in,
	// configuration
	input wire [1:0] func_in,
	input wire [1:0] latch_in,
	input wire invert_in,
	input wire [W-1:0] thresh_in,
	input wire [6:0] hyst_pct_in,
	// flow
	input wire [W-1:0] damped_mag_in,
	input wire damped_rev_in,
	input wire pulse_req_in,
	input wire clear_latch_in,
	// result: 1 means transistor conducting
	output reg active_out
);
	reg alarm; // normal alarm state before invert
	reg [7:0] pulse_pend; // pulses waiting to go out
	reg [31:0] pulse_cnt; // half-period timer
	reg pulse_lvl; // pulse train level
	wire [W+6:0] hb_prod; // thresh * pct, no overflow at W+7 bits
	wire [W+6:0] half_band;
	wire [W-1:0] on_lvl;
	wire [W-1:0] off_lvl;
	wire [W:0] on_sum;

	// half the band = thresh * pct / 200
	assign hb_prod = thresh_in * hyst_pct_in;
	assign half_band = hb_prod / 8'hC8;
	assign on_sum = {1'b0, thresh_in} + {1'b0, half_band[W-1:0]};
	// saturate on high side, floor at zero on low side
	assign on_lvl = on_sum[W] ? {W{1'b1}} : on_sum[W-1:0];
	assign off_lvl = (half_band[W-1:0] > thresh_in) ? {W{1'b0}} :
		thresh_in - half_band[W-1:0];

	// alarm state, latching or hysteresis
	always @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			alarm <= 1'b0;
		end else if (latch_in == `FPA_LATCH_NONE) begin
			if (damped_mag_in >= on_lvl) begin
				alarm <= 1'b1;
			end else if (damped_mag_in <= off_lvl) begin
				alarm <= 1'b0;
			end
		end else if (latch_in == `FPA_LATCH_HIGH) begin
			// set beats clear so a live trip is not lost
			if (damped_mag_in > thresh_in) begin
				alarm <= 1'b1;
			end else if (clear_latch_in) begin
				alarm <= 1'b0;
			end
		end else begin
			if (damped_mag_in < thresh_in) begin
				alarm <= 1'b1;
			end else if (clear_latch_in) begin
				alarm <= 1'b0;
			end
		end
	end

	// pulse train: each request is one full pulse, queued if busy
	always @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			pulse_pend <= 8'h00;
			pulse_cnt <= 32'h00000000;
			pulse_lvl <= 1'b0;
		end else begin
			if (pulse_cnt != 32'h00000000) begin
				pulse_cnt <= pulse_cnt - 32'h00000001;
				pulse_pend <= pulse_pend + {7'h00, pulse_req_in &
					(pulse_pend != 8'hFF)};
			end else if (pulse_lvl) begin
				pulse_lvl <= 1'b0;
				pulse_cnt <= PULSE_MIN;
				pulse_pend <= pulse_pend + {7'h00, pulse_req_in &
					(pulse_pend != 8'hFF)};
			end else if (pulse_pend != 8'h00 || pulse_req_in) begin
				pulse_lvl <= 1'b1;
				pulse_cnt <= PULSE_MIN;
				pulse_pend <= pulse_pend - {7'h00, ~pulse_req_in &
					(pulse_pend != 8'h00)};
			end
		end
	end

	// select the one function of this pin
	always @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			active_out <= 1'b0;
		end else begin
			case (func_in)
			`FPA_FN_PULSE: active_out <= pulse_lvl;
			`FPA_FN_REVERSE: active_out <= damped_rev_in ^ invert_in;
			`FPA_FN_SINGLE: active_out <= alarm ^ invert_in;
			default: active_out <= alarm ^ invert_in;
			endcase
		end
	end
endmodule
`default_nettype wire

// *** fpa_top.v ***
// flow output pins, alarms, damping and totaliser
// Function
// - reverse flow ignored unless decrement option set, except by alarms at damping level 0
// - option set: total decrements, reverse pulses emitted
// - each pin unused, input or output
// - output pin runs exactly one function
// - pulses per volume, rate tracks flow
// - idle: sinking pin open, sourcing at zero
// - reverse function: steady level on reverse
// - no latching: on at top of band, off at bottom of band
// - high latching: latch when above threshold
// - low latching: latch when below threshold
// - latched alarm holds until reset event
// - clear by other pin input or hold
// - hysteresis band centred on threshold
// - invert gives complement of alarm
// - alarms use damped flow, pulses undamped
// - damping levels roughly doubling averaging time
// - total cleared by right button or input
// - flow below cut-off forced to zero
`default_nettype none
`include "fpa_map.vh"
module fpa_top #(
	parameter W = 24,
	parameter VOL_W = 16,
	parameter [31:0] HOLD_CYCLES = `FPA_HOLD_CYCLES,
	parameter [31:0] PULSE_MIN = `FPA_PULSE_MIN_CYCLES
) (
	// clock and reset
	input wire sys_clk_in,
	input wire sys_rst_in,
	// register port
	input wire [3:0] reg_addr_in,
	input wire [31:0] reg_wdata_in,
	input wire reg_wr_in,
	input wire reg_rd_in,
	output reg [31:0] reg_rdata_out,
	// flow measurement from the sensing logic
	input wire flow_valid_in,
	input wire [W-1:0] flow_mag_in,
	input wire flow_rev_in,
	input wire [VOL_W-1:0] vol_in,
	// local buttons and display state (pins, asynchronous)
	input wire btn_left_in,
	input wire btn_right_in,
	input wire total_shown_in,
	// transistor pins: sinking (a) and sourcing (b)
	input wire pin_a_in,
	input wire pin_b_in,
	output wire pin_a_sink_out,
	output wire pin_a_oe_out,
	output wire pin_b_src_out,
	output wire pin_b_oe_out,
	// running total
	output reg [31:0] total_out
);
	// register offsets
	localparam [3:0] A_CFG = `FPA_A_CFG; // pin assignment, options
	localparam [3:0] A_PINA = `FPA_A_PINA; // pin a function setup
	localparam [3:0] A_PINB = `FPA_A_PINB; // pin b function setup
	localparam [3:0] A_THA = `FPA_A_THA; // pin a threshold
	localparam [3:0] A_THB = `FPA_A_THB; // pin b threshold
	localparam [3:0] A_CUT = `FPA_A_CUT; // cut-off level
	localparam [3:0] A_PPV = `FPA_A_PPV; // pulses per volume unit
	localparam [3:0] A_TOT = `FPA_A_TOT; // running total
	localparam [3:0] A_STAT = `FPA_A_STAT; // live state
	localparam [3:0] A_UNIT = `FPA_A_UNIT; // volume counts per unit

	// software-written configuration
	reg [1:0] assign_a, assign_b; // pin assignment
	reg neg_en; // decrement total for reverse flow
	reg [2:0] damp_lvl; // damping level
	reg [1:0] func_a, func_b;
	reg [1:0] latch_a, latch_b;
	reg inv_a, inv_b;
	reg [6:0] hyst_a, hyst_b;
	reg [W-1:0] th_a, th_b;
	reg [W-1:0] cut_lvl;
	reg [15:0] ppv; // pulses per unit
	reg [31:0] unit_vol; // volume counts making one unit

	// synchronised pin inputs
	wire btn_l, btn_r, shown, in_a, in_b;
	fpa_sync u_sl (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
		.d_in(btn_left_in), .q_out(btn_l));
	fpa_sync u_sr (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
		.d_in(btn_right_in), .q_out(btn_r));
	fpa_sync u_sd (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
		.d_in(total_shown_in), .q_out(shown));
	fpa_sync u_sa (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
		.d_in(pin_a_in), .q_out(in_a));
	fpa_sync u_sb (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
		.d_in(pin_b_in), .q_out(in_b));

	// cut-off and direction gate
	wire [W-1:0] mag_cut;
	wire rev_ok;
	wire fwd_ok;
	assign mag_cut = (flow_mag_in < cut_lvl) ? {W{1'b0}} : flow_mag_in;
	// reverse samples count only when the option is set
	assign rev_ok = flow_rev_in & neg_en & (mag_cut != {W{1'b0}});
	assign fwd_ok = ~flow_rev_in;

	// damping: first-order filter, shift k doubles time per level
	reg [W+7:0] damp_acc; // magnitude scaled by 2^8
	reg damp_rev;
	wire [W-1:0] damped_mag;
	wire [W+7:0] target;
	wire [3:0] shft;
	assign target = (fwd_ok | rev_ok) ? {mag_cut, 8'h00} : {(W+8){1'b0}};
	assign shft = {1'b0, damp_lvl} + 4'h1;
	assign damped_mag = (damp_lvl == 3'h0) ? mag_cut : damp_acc[W+7:8];

	// filter update once per flow sample
	always @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			damp_acc <= {(W+8){1'b0}};
			damp_rev <= 1'b0;
		end else if (flow_valid_in) begin
			if (target >= damp_acc) begin
				damp_acc <= damp_acc + ((target - damp_acc) >> shft);
			end else begin
				damp_acc <= damp_acc - ((damp_acc - target) >> shft);
			end
			damp_rev <= rev_ok;
		end
	end

	// undamped volume to pulse requests
	reg [47:0] pulse_acc; // volume * ppv accumulator
	reg pulse_req;
	wire use_vol;
	wire [47:0] vol_ppv;
	assign use_vol = flow_valid_in & (mag_cut != {W{1'b0}}) &
		(fwd_ok | rev_ok);
	assign vol_ppv = {{(32-VOL_W){1'b0}}, vol_in} * ppv;

	// one request per unit crossed; ppv kept low by software
	always @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			pulse_acc <= 48'h000000000000;
			pulse_req <= 1'b0;
		end else begin
			pulse_req <= 1'b0;
			if (pulse_acc >= {16'h0000, unit_vol} && unit_vol != 32'h0) begin
				pulse_acc <= pulse_acc - {16'h0000, unit_vol} +
					(use_vol ? vol_ppv : 48'h000000000000);
				pulse_req <= 1'b1;
			end else if (use_vol) begin
				pulse_acc <= pulse_acc + vol_ppv;
			end
		end
	end

	// remote inputs: rising edge on a pin set as input
	reg in_a_d, in_b_d;
	wire remote_a, remote_b;
	assign remote_a = (assign_a == `FPA_PIN_INPUT) & in_a & ~in_a_d;
	assign remote_b = (assign_b == `FPA_PIN_INPUT) & in_b & ~in_b_d;

	// left button hold counter for latch clear
	reg [31:0] hold_cnt;
	reg hold_fire;
	reg btn_r_d;
	always @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			hold_cnt <= 32'h0;
			hold_fire <= 1'b0;
			in_a_d <= 1'b0;
			in_b_d <= 1'b0;
			btn_r_d <= 1'b0;
		end else begin
			in_a_d <= in_a;
			in_b_d <= in_b;
			btn_r_d <= btn_r;
			hold_fire <= 1'b0;
			if (!btn_l) begin
				hold_cnt <= 32'h0;
			end else if (hold_cnt == HOLD_CYCLES - 32'h1) begin
				hold_cnt <= HOLD_CYCLES; // fire once per hold
				hold_fire <= 1'b1;
			end else if (hold_cnt < HOLD_CYCLES) begin
				hold_cnt <= hold_cnt + 32'h1;
			end
		end
	end

	// latch clear for each pin comes from the other pin or the hold
	wire clr_a, clr_b;
	assign clr_a = hold_fire | remote_b;
	assign clr_b = hold_fire | remote_a;

	// total clear: right button while shown, or any remote input
	wire tot_clr;
	assign tot_clr = (btn_r & ~btn_r_d & shown) | remote_a | remote_b;

	// running total in volume counts
	always @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			total_out <= 32'h0;
		end else if (tot_clr) begin
			total_out <= 32'h0;
		end else if (use_vol && rev_ok) begin
			total_out <= total_out - {{(32-VOL_W){1'b0}}, vol_in};
		end else if (use_vol) begin
			total_out <= total_out + {{(32-VOL_W){1'b0}}, vol_in};
		end
	end

	// the two output pins
	wire act_a, act_b;
	fpa_alarm #(.W(W), .PULSE_MIN(PULSE_MIN)) u_pa (
		.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
		.func_in(func_a), .latch_in(latch_a), .invert_in(inv_a),
		.thresh_in(th_a), .hyst_pct_in(hyst_a),
		.damped_mag_in(damped_mag), .damped_rev_in(damp_rev),
		.pulse_req_in(pulse_req), .clear_latch_in(clr_a),
		.active_out(act_a));
	fpa_alarm #(.W(W), .PULSE_MIN(PULSE_MIN)) u_pb (
		.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
		.func_in(func_b), .latch_in(latch_b), .invert_in(inv_b),
		.thresh_in(th_b), .hyst_pct_in(hyst_b),
		.damped_mag_in(damped_mag), .damped_rev_in(damp_rev),
		.pulse_req_in(pulse_req), .clear_latch_in(clr_b),
		.active_out(act_b));

	// drive only when output and active; idle is off
	assign pin_a_oe_out = (assign_a == `FPA_PIN_OUTPUT) & act_a;
	assign pin_a_sink_out = 1'b0; // sinking switch pulls low when on
	assign pin_b_oe_out = (assign_b == `FPA_PIN_OUTPUT) & act_b;
	assign pin_b_src_out = pin_b_oe_out; // sourcing: high only when on

	// register writes
	always @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			assign_a <= `FPA_PIN_UNUSED;
			assign_b <= `FPA_PIN_UNUSED;
			neg_en <= 1'b0;
			damp_lvl <= 3'h0;
			func_a <= `FPA_FN_PULSE;
			func_b <= `FPA_FN_PULSE;
			latch_a <= `FPA_LATCH_NONE;
			latch_b <= `FPA_LATCH_NONE;
			inv_a <= 1'b0;
			inv_b <= 1'b0;
			hyst_a <= 7'h00;
			hyst_b <= 7'h00;
			th_a <= {W{1'b0}};
			th_b <= {W{1'b0}};
			cut_lvl <= {W{1'b0}};
			ppv <= `FPA_PPV_RST;
			unit_vol <= `FPA_UNIT_RST;
		end else if (reg_wr_in) begin
			if (reg_addr_in == A_CFG) begin
				assign_a <= reg_wdata_in[1:0];
				assign_b <= reg_wdata_in[3:2];
				neg_en <= reg_wdata_in[4];
				damp_lvl <= (reg_wdata_in[10:8] > `FPA_DAMP_MAX) ?
					`FPA_DAMP_MAX : reg_wdata_in[10:8];
			end else if (reg_addr_in == A_PINA) begin
				func_a <= reg_wdata_in[1:0];
				latch_a <= reg_wdata_in[3:2];
				inv_a <= reg_wdata_in[4];
				hyst_a <= reg_wdata_in[14:8];
			end else if (reg_addr_in == A_PINB) begin
				func_b <= reg_wdata_in[1:0];
				latch_b <= reg_wdata_in[3:2];
				inv_b <= reg_wdata_in[4];
				hyst_b <= reg_wdata_in[14:8];
			end else if (reg_addr_in == A_THA) begin
				th_a <= reg_wdata_in[W-1:0];
			end else if (reg_addr_in == A_THB) begin
				th_b <= reg_wdata_in[W-1:0];
			end else if (reg_addr_in == A_CUT) begin
				cut_lvl <= reg_wdata_in[W-1:0];
			end else if (reg_addr_in == A_PPV) begin
				ppv <= reg_wdata_in[15:0]; // software bounds this
			end else if (reg_addr_in == A_UNIT) begin
				unit_vol <= reg_wdata_in;
			end
		end
	end

	// register reads, data one cycle later; unmapped reads zero
	always @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			reg_rdata_out <= 32'h0;
		end else if (!reg_rd_in) begin
			reg_rdata_out <= 32'h0;
		end else if (reg_addr_in == A_CFG) begin
			reg_rdata_out <= {21'h0, damp_lvl, 3'h0, neg_en, assign_b,
				assign_a};
		end else if (reg_addr_in == A_PINA) begin
			reg_rdata_out <= {17'h0, hyst_a, 3'h0, inv_a, latch_a, func_a};
		end else if (reg_addr_in == A_PINB) begin
			reg_rdata_out <= {17'h0, hyst_b, 3'h0, inv_b, latch_b, func_b};
		end else if (reg_addr_in == A_THA) begin
			reg_rdata_out <= {{(32-W){1'b0}}, th_a};
		end else if (reg_addr_in == A_THB) begin
			reg_rdata_out <= {{(32-W){1'b0}}, th_b};
		end else if (reg_addr_in == A_CUT) begin
			reg_rdata_out <= {{(32-W){1'b0}}, cut_lvl};
		end else if (reg_addr_in == A_PPV) begin
			reg_rdata_out <= {16'h0, ppv};
		end else if (reg_addr_in == A_TOT) begin
			reg_rdata_out <= total_out;
		end else if (reg_addr_in == A_STAT) begin
			reg_rdata_out <= {28'h0, damp_rev, act_b, act_a, btn_l};
		end else if (reg_addr_in == A_UNIT) begin
			reg_rdata_out <= unit_vol;
		end else begin
			reg_rdata_out <= 32'h0;
		end
	end
endmodule
`default_nettype wire

// *** fpa_far_end.sv ***
// far-side equipment model reading the two transistor pins
`default_nettype none
module fpa_far_end (
	// drive from the block
	input wire logic pin_a_sink_in,
	input wire logic pin_a_oe_in,
	input wire logic pin_b_src_in,
	input wire logic pin_b_oe_in,
	// external switches used when a pin is an input
	input wire logic ext_a_low_in,
	input wire logic ext_b_high_in,
	// wire levels and pulse count
	output logic line_a_out,
	output logic line_b_out,
	output var int pulse_count_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// pull-up near the target: open switch reads high
	assign line_a_out = !((pin_a_oe_in && !pin_a_sink_in) || ext_a_low_in);
	// load to ground: an idle sourcing pin reads zero
	assign line_b_out = (pin_b_oe_in && pin_b_src_in) || ext_b_high_in;
	// a pulse is counted when the sinking transistor pulls the line low
	initial pulse_count_out = 0;
	always @(negedge line_a_out) begin
		pulse_count_out = pulse_count_out + 1;
	end
endmodule
`default_nettype wire

// *** fpa_top_assertions.sv ***
// port checker for the flow output pin and alarm block
`default_nettype none
module fpa_top_assertions (
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	// register port
	input wire logic [3:0] reg_addr_in,
	input wire logic reg_rd_in,
	input wire logic [31:0] reg_rdata_out,
	// flow, buttons and pins
	input wire logic flow_valid_in,
	input wire logic btn_right_in,
	input wire logic total_shown_in,
	input wire logic pin_a_in,
	input wire logic pin_b_in,
	input wire logic pin_a_sink_out,
	input wire logic pin_a_oe_out,
	input wire logic pin_b_oe_out,
	input wire logic [31:0] total_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (sys_rst_in);
	a_rdata_quiet: assert property (!$past(reg_rd_in) |->
		reg_rdata_out == 32'h0) else $error("read data outside read slot");
	a_total_read: assert property ($past(reg_rd_in && reg_addr_in == 4'h7)
		|-> reg_rdata_out == $past(total_out)) else $error("total read");
	a_unmapped_zero: assert property ($past(reg_rd_in && reg_addr_in > 4'h9)
		|-> reg_rdata_out == 32'h0) else $error("unmapped read not zero");
	a_status_spare: assert property ($past(reg_rd_in && reg_addr_in == 4'h8)
		|-> reg_rdata_out[31:4] == 28'h0) else $error("status spare bits");
	a_sink_low: assert property (pin_a_sink_out == 1'b0)
		else $error("sinking pin drives high");
	// reset must hold both transistors off, so no disable here
	a_reset_idle: assert property (disable iff (1'b0) sys_rst_in |->
		!pin_a_oe_out && !pin_b_oe_out && total_out == 32'h0)
		else $error("outputs active in reset");
	a_release_idle: assert property (disable iff (1'b0)
		$fell(sys_rst_in) |-> (!pin_a_oe_out && !pin_b_oe_out) [*2])
		else $error("unused pins driven after reset");
	// six quiet cycles cover synchroniser and edge latency
	a_total_quiet: assert property ((!flow_valid_in && !btn_right_in &&
		$stable(pin_a_in) && $stable(pin_b_in)) [*6] |=> $stable(total_out))
		else $error("total moved without cause");
	a_right_clear: assert property ($rose(btn_right_in) ##1
		(btn_right_in && total_shown_in && !flow_valid_in) [*5] |->
		##[0:3] total_out == 32'h0) else $error("total not cleared");
endmodule
bind fpa_top fpa_top_assertions u_fpa_top_assertions (
	.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
	.reg_addr_in(reg_addr_in), .reg_rd_in(reg_rd_in),
	.reg_rdata_out(reg_rdata_out), .flow_valid_in(flow_valid_in),
	.btn_right_in(btn_right_in), .total_shown_in(total_shown_in),
	.pin_a_in(pin_a_in), .pin_b_in(pin_b_in),
	.pin_a_sink_out(pin_a_sink_out), .pin_a_oe_out(pin_a_oe_out),
	.pin_b_oe_out(pin_b_oe_out), .total_out(total_out));
`default_nettype wire

// *** flow_output_pin_alarm_logic_test.sv ***
// self-checking bench for the flow output pin and alarm block
`default_nettype none
module flow_output_pin_alarm_logic_test;
	timeunit 1ns;
	timeprecision 1ps;
	// stimulus, all but the clock driven by non-blocking assignment
	logic clk = 1'b0;
	logic rst = 1'b0; // raised at time zero so the reset edge is seen
	logic [3:0] addr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic fv = 1'b0;
	logic [23:0] mag = 24'h0;
	logic rev = 1'b0;
	logic [15:0] vol = 16'h0;
	logic btn_l = 1'b0;
	logic btn_r = 1'b0;
	logic shown = 1'b0;
	logic ext_a = 1'b0;
	logic ext_b = 1'b0;
	// observed
	wire logic [31:0] rdata, total;
	wire logic sink_a, oe_a, src_b, oe_b, line_a, line_b;
	int pulses;
	int err_count = 0;
	int num_checks = 0;
	int cyc = 0;
	int p0;
	always #4 clk = ~clk;
	// counts shortened so the run stays small
	fpa_top #(.HOLD_CYCLES(32'h32), .PULSE_MIN(32'h4)) u_fpa_top (
		.sys_clk_in(clk), .sys_rst_in(rst), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s),
		.reg_rdata_out(rdata), .flow_valid_in(fv), .flow_mag_in(mag),
		.flow_rev_in(rev), .vol_in(vol), .btn_left_in(btn_l),
		.btn_right_in(btn_r), .total_shown_in(shown), .pin_a_in(line_a),
		.pin_b_in(line_b), .pin_a_sink_out(sink_a), .pin_a_oe_out(oe_a),
		.pin_b_src_out(src_b), .pin_b_oe_out(oe_b), .total_out(total));
	fpa_far_end u_fpa_far_end (.pin_a_sink_in(sink_a), .pin_a_oe_in(oe_a),
		.pin_b_src_in(src_b), .pin_b_oe_in(oe_b), .ext_a_low_in(ext_a),
		.ext_b_high_in(ext_b), .line_a_out(line_a), .line_b_out(line_b),
		.pulse_count_out(pulses));
	task close_out;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			$display("Error at %0t: got %h expected %h", $time, g, e);
			err_count++;
		end
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1;
		chk(rdata, e);
	endtask
	// one flow sample, then time to settle
	task smp(input logic [23:0] m, input logic r, input logic [15:0] v);
		@(posedge clk);
		fv <= 1'b1;
		mag <= m;
		rev <= r;
		vol <= v;
		@(posedge clk);
		fv <= 1'b0;
		repeat (20) @(posedge clk);
	endtask
	task ln(input logic a, input logic b);
		chk({30'h0, line_a, line_b}, {30'h0, a, b});
	endtask
	// hold the left button past the clear time
	task hold_left;
		btn_l <= 1'b1;
		repeat (70) @(posedge clk);
		btn_l <= 1'b0;
		repeat (5) @(posedge clk);
	endtask
	task t_reset;
		rd(4'h7, 32'h0);
		rd(4'h6, 32'h1);
		rd(4'h9, 32'h3E8);
		rd(4'hF, 32'h0);
		ln(1'b1, 1'b0);
	endtask
	// ten counts per unit, two pulses per unit: 25 counts give 5 pulses
	task t_pulse;
		wr(4'h9, 32'hA);
		wr(4'h6, 32'h2);
		wr(4'h5, 32'h0);
		wr(4'h1, 32'h0);
		wr(4'h0, 32'h2);
		p0 = pulses;
		smp(24'h1F4, 1'b0, 16'h19);
		smp(24'h1F4, 1'b0, 16'h19);
		repeat (100) @(posedge clk);
		chk(pulses - p0, 32'hA);
		rd(4'h7, 32'h32);
		ln(1'b1, 1'b0);
		smp(24'h1F4, 1'b1, 16'h19);
		repeat (60) @(posedge clk);
		chk(pulses - p0, 32'hA);
		rd(4'h7, 32'h32);
		wr(4'h0, 32'h12);
		smp(24'h1F4, 1'b1, 16'h19);
		repeat (60) @(posedge clk);
		chk(pulses - p0, 32'hF);
		rd(4'h7, 32'h19);
		wr(4'h5, 32'h64);
		smp(24'h32, 1'b0, 16'h19);
		rd(4'h7, 32'h19);
	endtask
	// threshold 100, band 20 percent: on at 110, off at 90
	task t_none;
		wr(4'h5, 32'h0);
		wr(4'h4, 32'h64);
		wr(4'h2, 32'h1401);
		wr(4'h0, 32'h8);
		smp(24'h69, 1'b0, 16'h1);
		ln(1'b1, 1'b0);
		smp(24'h6E, 1'b0, 16'h1);
		ln(1'b1, 1'b1);
		smp(24'h5F, 1'b0, 16'h1);
		ln(1'b1, 1'b1);
		smp(24'h5A, 1'b0, 16'h1);
		ln(1'b1, 1'b0);
		wr(4'h2, 32'h1411);
		smp(24'h5A, 1'b0, 16'h1);
		ln(1'b1, 1'b1);
		smp(24'h6E, 1'b0, 16'h1);
		ln(1'b1, 1'b0);
	endtask
	// pin a latches high, pin b latches low, both at 100
	task t_latch;
		wr(4'h3, 32'h64);
		wr(4'h1, 32'h5);
		wr(4'h2, 32'h9);
		wr(4'h0, 32'hA);
		// states left from earlier modes are cleared at the threshold
		smp(24'h64, 1'b0, 16'h1);
		hold_left;
		ln(1'b1, 1'b0);
		smp(24'h96, 1'b0, 16'h1);
		ln(1'b0, 1'b0);
		smp(24'h14, 1'b0, 16'h1);
		ln(1'b0, 1'b1);
		smp(24'h64, 1'b0, 16'h1);
		ln(1'b0, 1'b1);
		hold_left;
		ln(1'b1, 1'b0);
		smp(24'h14, 1'b0, 16'h1);
		smp(24'h64, 1'b0, 16'h1);
		ln(1'b1, 1'b1);
		wr(4'h0, 32'h9);
		ext_a <= 1'b1;
		repeat (5) @(posedge clk);
		ext_a <= 1'b0;
		repeat (8) @(posedge clk);
		ln(1'b1, 1'b0);
		rd(4'h7, 32'h0);
	endtask
	task t_rev;
		wr(4'h2, 32'h3);
		wr(4'h0, 32'h18);
		smp(24'hC8, 1'b0, 16'h3);
		ln(1'b1, 1'b0);
		smp(24'hC8, 1'b1, 16'h1);
		ln(1'b1, 1'b1);
		rd(4'h7, 32'h2);
		shown <= 1'b1;
		repeat (3) @(posedge clk);
		btn_r <= 1'b1;
		repeat (10) @(posedge clk);
		btn_r <= 1'b0;
		shown <= 1'b0;
		rd(4'h7, 32'h0);
	endtask
	// level 1 closes a quarter of the gap: 50, 87, 115
	task t_damp;
		wr(4'h2, 32'h1);
		wr(4'h0, 32'h8);
		// at level 0 each zero sample halves the filter; drain it fully
		repeat (18) smp(24'h0, 1'b0, 16'h0);
		wr(4'h0, 32'h108);
		smp(24'hC8, 1'b0, 16'h0);
		ln(1'b1, 1'b0);
		smp(24'hC8, 1'b0, 16'h0);
		ln(1'b1, 1'b0);
		smp(24'hC8, 1'b0, 16'h0);
		ln(1'b1, 1'b1);
	endtask
	// hang guard: the sequence needs about 1400 cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			close_out;
		end
	end
	initial begin
		rst <= 1'b1;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_pulse;
		t_none;
		t_latch;
		t_rev;
		t_damp;
		close_out;
	end
endmodule
`default_nettype wire
